// *** logic/wdg_pkg.sv ***
// package: constants and types for the low-power watchdog
`default_nettype none

package wdg_pkg;

	// =====================================================
	// register map and fields
	localparam logic [15:0] WDG_CTRL_ADDR = 16'h002A;
	localparam int WDG_ACT_POS = 7;
	localparam int WDG_TOP_POS = 6;
	localparam logic [7:0] WDG_CTRL_RESET = 8'h7F;
	localparam logic [6:0] WDG_CNT_RESET = 7'h7F;
	localparam logic [6:0] WDG_CNT_TRIP = 7'h40;

	// =====================================================
	// timing
	localparam int WDG_CLK_NS = 40;
	localparam int WDG_PRESCALE_DIV = 16384;
	localparam int WDG_RST_PULSE_NS = 500;
	localparam logic [3:0] WDG_RST_PULSE_CYC =
		4'((WDG_RST_PULSE_NS + WDG_CLK_NS - 1) / WDG_CLK_NS);
	localparam int WDG_DELAY_SHORT = 256;
	localparam int WDG_DELAY_LONG = 4096;
	localparam logic [11:0] WDG_DLY_SHORT_LD = 12'(WDG_DELAY_SHORT - 1);
	localparam logic [11:0] WDG_DLY_LONG_LD = 12'(WDG_DELAY_LONG - 1);

	// =====================================================
	// types
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} wdg_bus_s;

	typedef enum logic [2:0] {
		WDG_RUN = 3'b000,
		WDG_HALT_DEC = 3'b001,
		WDG_HALT_STOP = 3'b010,
		WDG_ACT_HALT = 3'b011,
		WDG_RESTART = 3'b100
	} wdg_state_e;

endpackage : wdg_pkg

`default_nettype wire

// *** logic/wdg_prescaler.sv ***
// module: free-running divider giving one tick per counter step
`default_nettype none

module wdg_prescaler import wdg_pkg::*; (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// step enable
	output logic o_tick
);

	logic [13:0] div;
	logic [13:0] next_div;
	logic next_tick;

	// =====================================================
	// divider, never disturbed by register writes
	always_comb begin
		next_div = div + 14'h0001;
		next_tick = (div == 14'(WDG_PRESCALE_DIV - 2));
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			div <= 14'h0000;
			o_tick <= 1'b0;
		end else begin
			div <= next_div;
			o_tick <= next_tick;
		end
	end

	// no second tick in the two cycles after a tick
	a_tick_spacing: assert property (@(posedge i_mclk) disable iff (i_srst)
		o_tick |=> !o_tick ##1 !o_tick)
		else $error("prescaler tick repeated too soon");

endmodule : wdg_prescaler

`default_nettype wire

// *** logic/wdg_rst_pulse.sv ***
// module: stretches a reset request into a low pulse on the reset pin
`default_nettype none

module wdg_rst_pulse import wdg_pkg::*; (
	// clock and power-on clear
	input wire logic i_mclk,
	input wire logic i_por,
	// request
	input wire logic i_fire,
	// reset pin drive
	output logic o_rst_n
);

	logic [3:0] cnt;
	logic [3:0] next_cnt;

	// =====================================================
	// kept off the system reset so the pulse is not cut short
	always_comb begin
		if (i_fire) begin
			next_cnt = WDG_RST_PULSE_CYC;
		end else if (cnt != 4'h0) begin
			next_cnt = cnt - 4'h1;
		end else begin
			next_cnt = 4'h0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_por) begin
			cnt <= 4'h0;
			o_rst_n <= 1'b1;
		end else begin
			cnt <= next_cnt;
			o_rst_n <= (next_cnt == 4'h0);
		end
	end

	a_pulse_width: assert property (@(posedge i_mclk) disable iff (i_por)
		$fell(o_rst_n) |-> ##12 !o_rst_n)
		else $error("reset pulse shorter than 500 ns");

endmodule : wdg_rst_pulse

`default_nettype wire

// *** logic/wdg_core.sv ***
// module: watchdog with halt and active-halt handling
//
// Added by the designer: strobed register access.
`default_nettype none

module wdg_core import wdg_pkg::*; (
	// clock and resets
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_por,
	// register port
	input wire wdg_bus_s i_bus,
	output logic [7:0] o_rdata,
	// cpu and clock controller events
	input wire logic i_halt_exec,
	input wire logic i_ext_irq,
	input wire logic i_osc_irq,
	input wire logic i_rtc_interrupt_enable,
	// option settings
	input wire logic i_hw_wdg_opt,
	input wire logic i_halt_reset_option,
	input wire logic i_long_delay_sel,
	// status and reset pin
	output logic o_halted,
	output logic o_active_halt,
	output logic o_rst_n
);

	wdg_state_e state;
	wdg_state_e next_state;
	logic activation_bit;
	logic next_act;
	logic [6:0] cnt;
	logic [6:0] next_cnt;
	logic [11:0] dly;
	logic [11:0] next_dly;
	logic was_ahalt;
	logic next_was_ahalt;
	logic fire;
	logic next_fire;
	logic tick;
	logic ctrl_hit;
	logic wr_ctrl;
	logic enabled;
	logic [11:0] dly_load;

	// =====================================================
	// step prescaler and reset pulse
	wdg_prescaler u_presc (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.o_tick(tick)
	);

	wdg_rst_pulse u_pulse (
		.i_mclk(i_mclk),
		.i_por(i_por),
		.i_fire(fire),
		.o_rst_n(o_rst_n)
	);

	// decode and restart length
	assign ctrl_hit = (i_bus.addr == WDG_CTRL_ADDR);
	assign wr_ctrl = i_bus.wr && ctrl_hit;
	assign dly_load = i_long_delay_sel ? WDG_DLY_LONG_LD
		: WDG_DLY_SHORT_LD;

	// =====================================================
	// control register, counter and power-mode sequencing
	always_comb begin
		next_state = state;
		next_act = activation_bit;
		next_cnt = cnt;
		next_dly = dly;
		next_was_ahalt = was_ahalt;
		next_fire = 1'b0;
		// activation only ever sets
		if (wr_ctrl) begin
			next_act = activation_bit | i_bus.wdata[WDG_ACT_POS];
		end
		enabled = next_act | i_hw_wdg_opt;
		case (state)
			WDG_RUN: begin
				if (wr_ctrl) begin
					next_cnt = i_bus.wdata[6:0];
				end else if (tick) begin
					next_cnt = cnt - 7'h01;
				end
				// top bit clearing while enabled, by step or by write
				if (enabled && cnt[WDG_TOP_POS] && !next_cnt[WDG_TOP_POS]) begin
					next_fire = 1'b1;
				end
				if (enabled && wr_ctrl && !i_bus.wdata[WDG_TOP_POS]) begin
					next_fire = 1'b1;
				end
				if (i_halt_exec) begin
					if (i_rtc_interrupt_enable) begin
						next_state = WDG_ACT_HALT;
						next_was_ahalt = 1'b1;
					end else if (i_halt_reset_option) begin
						next_fire = 1'b1;
					end else begin
						next_state = WDG_HALT_DEC;
					end
				end
			end
			WDG_HALT_DEC: begin
				// one last step, with no reset from it
				if (tick) begin
					next_cnt = cnt - 7'h01;
					next_state = WDG_HALT_STOP;
				end
				if (i_ext_irq) begin
					next_state = WDG_RESTART;
					next_dly = dly_load;
				end
			end
			WDG_HALT_STOP: begin
				if (i_ext_irq) begin
					next_state = WDG_RESTART;
					next_dly = dly_load;
				end
			end
			WDG_ACT_HALT: begin
				// frozen until an interrupt wakes the core
				if (i_osc_irq || i_ext_irq) begin
					next_state = WDG_RUN;
					next_was_ahalt = 1'b0;
				end
			end
			WDG_RESTART: begin
				if (dly == 12'h000) begin
					next_state = WDG_RUN;
					next_was_ahalt = 1'b0;
				end else begin
					next_dly = dly - 12'h001;
				end
			end
			default: begin
				next_state = WDG_RUN;
			end
		endcase
	end

	// registers; was_ahalt survives the system reset
	always_ff @(posedge i_mclk) begin
		if (i_por) begin
			was_ahalt <= 1'b0;
		end else begin
			was_ahalt <= next_was_ahalt;
		end
		if (i_srst) begin
			activation_bit <= WDG_CTRL_RESET[WDG_ACT_POS];
			cnt <= WDG_CNT_RESET;
			fire <= 1'b0;
			if (was_ahalt) begin
				state <= WDG_RESTART;
				dly <= dly_load;
			end else begin
				state <= WDG_RUN;
				dly <= 12'h000;
			end
		end else begin
			activation_bit <= next_act;
			cnt <= next_cnt;
			fire <= next_fire;
			state <= next_state;
			dly <= next_dly;
		end
	end

	// =====================================================
	// read port and status
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_rdata <= 8'h00;
			o_halted <= 1'b0;
			o_active_halt <= 1'b0;
		end else begin
			o_rdata <= (i_bus.rd && ctrl_hit) ?
				{activation_bit, cnt} : 8'h00;
			o_halted <= (next_state == WDG_HALT_DEC) ||
				(next_state == WDG_HALT_STOP);
			o_active_halt <= (next_state == WDG_ACT_HALT);
		end
	end

	// =====================================================
	// checks
	a_step_only_tick: assert property (@(posedge i_mclk) disable iff (i_srst)
		(state == WDG_RUN && !wr_ctrl && !tick && !i_halt_exec)
		|=> $stable(cnt))
		else $error("counter moved without a prescaler tick");

	a_trip_fires: assert property (@(posedge i_mclk) disable iff (i_srst)
		(state == WDG_RUN && activation_bit && tick && !wr_ctrl &&
		cnt == WDG_CNT_TRIP) |=> fire ##1 !o_rst_n)
		else $error("no reset after 40h to 3Fh step");

	a_act_sticky: assert property (@(posedge i_mclk) disable iff (i_srst)
		activation_bit |=> activation_bit)
		else $error("activation bit cleared without reset");

	a_read_value: assert property (@(posedge i_mclk)
		disable iff (i_srst)
		(i_bus.rd && ctrl_hit) |=> o_rdata == $past({activation_bit, cnt}))
		else $error("control register read mismatch");

	a_reset_value: assert property (@(posedge i_mclk)
		$past(i_srst) |-> {activation_bit, cnt} == WDG_CTRL_RESET)
		else $error("control register not 7Fh after reset");

	a_hw_option: assert property (@(posedge i_mclk) disable iff (i_srst)
		(state == WDG_RUN && i_hw_wdg_opt && tick && !wr_ctrl &&
		cnt == WDG_CNT_TRIP) |=> fire)
		else $error("hardware watchdog did not fire");

	a_halt_frozen: assert property (@(posedge i_mclk) disable iff (i_srst)
		(state == WDG_HALT_STOP && !i_ext_irq)
		|=> $stable(cnt) && !fire)
		else $error("counter moved in plain halt");

	a_halt_wake: assert property (@(posedge i_mclk) disable iff (i_srst)
		(state == WDG_HALT_STOP && i_ext_irq)
		|=> state == WDG_RESTART ##1 $stable(cnt))
		else $error("external wake skipped restart delay");

	a_halt_reset: assert property (@(posedge i_mclk) disable iff (i_srst)
		(state == WDG_RUN && i_halt_exec && !i_rtc_interrupt_enable &&
		i_halt_reset_option) |=> fire)
		else $error("halt did not produce a reset");

	a_ahalt_frozen: assert property (@(posedge i_mclk) disable iff (i_srst)
		(state == WDG_ACT_HALT) |=> $stable(cnt) && !fire)
		else $error("counter moved in active-halt");

	a_ahalt_wake: assert property (@(posedge i_mclk) disable iff (i_srst)
		(state == WDG_ACT_HALT && (i_osc_irq || i_ext_irq))
		|=> state == WDG_RUN)
		else $error("active-halt wake not immediate");

	a_ahalt_reset: assert property (@(posedge i_mclk) disable iff (i_srst)
		($past(i_srst) && $past(was_ahalt)) |-> state == WDG_RESTART)
		else $error("reset from active-halt skipped delay");

	// writes, enables, halt entry and restart length
	a_write_loads: assert property (@(posedge i_mclk)
		disable iff (i_srst)
		(state == WDG_RUN && wr_ctrl) |=> cnt == $past(i_bus.wdata[6:0]))
		else $error("counter not loaded by write");

	a_write_sets: assert property (@(posedge i_mclk)
		disable iff (i_srst)
		(wr_ctrl && i_bus.wdata[WDG_ACT_POS]) |=> activation_bit)
		else $error("activation bit not set by write");

	a_soft_reset: assert property (@(posedge i_mclk)
		disable iff (i_srst)
		(state == WDG_RUN && wr_ctrl && !i_bus.wdata[WDG_TOP_POS] &&
		(activation_bit || i_bus.wdata[WDG_ACT_POS] || i_hw_wdg_opt))
		|=> fire)
		else $error("top bit cleared by write without reset");

	a_disabled_quiet: assert property (@(posedge i_mclk)
		disable iff (i_srst)
		(state == WDG_RUN && !activation_bit && !i_hw_wdg_opt &&
		!i_halt_exec && !wr_ctrl) |=> !fire)
		else $error("disabled watchdog fired");

	a_halt_dec_quiet: assert property (@(posedge i_mclk)
		disable iff (i_srst)
		(state == WDG_HALT_DEC) |=> !fire)
		else $error("reset fired during plain halt");

	a_ahalt_enter: assert property (@(posedge i_mclk)
		disable iff (i_srst)
		(state == WDG_RUN && i_halt_exec && i_rtc_interrupt_enable)
		|=> state == WDG_ACT_HALT && o_active_halt)
		else $error("interrupt enable did not pick active-halt");

	a_restart_len: assert property (@(posedge i_mclk)
		disable iff (i_srst)
		((state != WDG_RESTART) ##1 (state == WDG_RESTART))
		|-> dly == dly_load)
		else $error("restart delay length wrong");

	a_restart_frozen: assert property (@(posedge i_mclk)
		disable iff (i_srst)
		(state == WDG_RESTART) |=> $stable(cnt))
		else $error("counter moved during restart delay");

	a_idle_rdata: assert property (@(posedge i_mclk)
		disable iff (i_srst)
		!(i_bus.rd && ctrl_hit) |=> o_rdata == 8'h00)
		else $error("read data not cleared when idle");

	a_reset_state: assert property (@(posedge i_mclk)
		disable iff (i_srst)
		($past(i_srst) && !$past(was_ahalt))
		|-> state == WDG_RUN && !o_halted)
		else $error("reset from plain halt not back in run");

endmodule : wdg_core

`default_nettype wire

// *** dv/test_wdg_core.sv ***
// testbench: directed scenarios for the low-power watchdog core
`default_nettype none

module test_wdg_core import wdg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// =====================================================
	// signals and counters
	logic i_mclk, i_srst, i_por, i_halt_exec, i_ext_irq, i_osc_irq;
	logic i_rtc_interrupt_enable, i_hw_wdg_opt, i_halt_reset_option;
	logic i_long_delay_sel, o_halted, o_active_halt, o_rst_n;
	wdg_bus_s i_bus;
	logic [7:0] o_rdata;
	int err_total = 0;
	int total_checks = 0;
	int n;

	wdg_core uut (.i_mclk(i_mclk), .i_srst(i_srst), .i_por(i_por),
		.i_bus(i_bus), .o_rdata(o_rdata), .i_halt_exec(i_halt_exec),
		.i_ext_irq(i_ext_irq), .i_osc_irq(i_osc_irq),
		.i_rtc_interrupt_enable(i_rtc_interrupt_enable),
		.i_hw_wdg_opt(i_hw_wdg_opt),
		.i_halt_reset_option(i_halt_reset_option),
		.i_long_delay_sel(i_long_delay_sel), .o_halted(o_halted),
		.o_active_halt(o_active_halt), .o_rst_n(o_rst_n));

	// 25 MHz clock
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end

	// =====================================================
	// shared tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : chk

	task automatic end_sim();
		if (err_total == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_mclk);
		i_bus.wr <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge i_mclk);
		i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_mclk);
		i_bus.rd <= 1'b0;
		#1;
		chk({8'h00, o_rdata}, {8'h00, exp});
	endtask : rd_chk

	// halt, external and oscillator events as one-cycle pulses
	task automatic ev(input logic [2:0] e);
		@(posedge i_mclk);
		{i_halt_exec, i_ext_irq, i_osc_irq} <= e;
		@(posedge i_mclk);
		{i_halt_exec, i_ext_irq, i_osc_irq} <= 3'h0;
		#1;
	endtask : ev

	// waits up to lim cycles for the pin to drop, then counts low cycles
	task automatic fire(input int lim, input int exp);
		int i;
		n = 0;
		for (i = 0; i < lim && o_rst_n !== 1'b0; i++) begin
			@(posedge i_mclk);
			#1;
		end
		for (i = 0; i < 40 && o_rst_n === 1'b0; i++) begin
			n++;
			@(posedge i_mclk);
			#1;
		end
		chk(16'(n), 16'(exp));
	endtask : fire

	task automatic quiet(input int cyc);
		int i;
		n = 0;
		for (i = 0; i < cyc; i++) begin
			@(posedge i_mclk);
			#1;
			if (o_rst_n !== 1'b1) n++;
		end
		chk(16'(n), 16'h0000);
	endtask : quiet

	task automatic do_reset();
		@(posedge i_mclk);
		i_srst <= 1'b1;
		repeat (8) @(posedge i_mclk);
		i_srst <= 1'b0;
		@(posedge i_mclk);
	endtask : do_reset

	// =====================================================
	// scenarios
	task automatic t_regs();
		rd_chk(WDG_CTRL_ADDR, 8'h7F);
		rd_chk(16'h002B, 8'h00);
		wr(16'h0029, 8'hC0);
		rd_chk(WDG_CTRL_ADDR, 8'h7F);
		wr(WDG_CTRL_ADDR, 8'h3F);
		fire(6, 0);
		rd_chk(WDG_CTRL_ADDR, 8'h3F);
		wr(WDG_CTRL_ADDR, 8'hFF);
		rd_chk(WDG_CTRL_ADDR, 8'hFF);
		wr(WDG_CTRL_ADDR, 8'h7F);
		rd_chk(WDG_CTRL_ADDR, 8'hFF);
		wr(WDG_CTRL_ADDR, 8'hBF);
		fire(6, WDG_RST_PULSE_CYC);
		do_reset();
		rd_chk(WDG_CTRL_ADDR, 8'h7F);
	endtask : t_regs

	task automatic t_opts();
		i_hw_wdg_opt <= 1'b1;
		wr(WDG_CTRL_ADDR, 8'h3F);
		fire(6, WDG_RST_PULSE_CYC);
		i_hw_wdg_opt <= 1'b0;
		do_reset();
		i_halt_reset_option <= 1'b1;
		ev(3'h4);
		fire(6, WDG_RST_PULSE_CYC);
		i_halt_reset_option <= 1'b0;
		do_reset();
	endtask : t_opts

	// reset out of active-halt: long restart delay, counter frozen
	task automatic t_restart();
		i_long_delay_sel <= 1'b1;
		i_rtc_interrupt_enable <= 1'b1;
		ev(3'h4);
		chk({15'h0000, o_active_halt}, 16'h0001);
		i_rtc_interrupt_enable <= 1'b0;
		do_reset();
		wr(WDG_CTRL_ADDR, 8'hC5);
		rd_chk(WDG_CTRL_ADDR, 8'hFF);
		repeat (300) @(posedge i_mclk);
		wr(WDG_CTRL_ADDR, 8'hC5);
		rd_chk(WDG_CTRL_ADDR, 8'hFF);
		repeat (3900) @(posedge i_mclk);
		wr(WDG_CTRL_ADDR, 8'hC5);
		rd_chk(WDG_CTRL_ADDR, 8'hC5);
		i_long_delay_sel <= 1'b0;
		do_reset();
	endtask : t_restart

	task automatic t_count();
		wr(WDG_CTRL_ADDR, 8'hC0);
		quiet(WDG_PRESCALE_DIV - 90);
		fire(150, WDG_RST_PULSE_CYC);
		do_reset();
	endtask : t_count

	task automatic t_active();
		wr(WDG_CTRL_ADDR, 8'hC0);
		i_rtc_interrupt_enable <= 1'b1;
		ev(3'h4);
		chk({15'h0000, o_active_halt}, 16'h0001);
		chk({15'h0000, o_halted}, 16'h0000);
		quiet(WDG_PRESCALE_DIV + 100);
		rd_chk(WDG_CTRL_ADDR, 8'hC0);
		ev(3'h1);
		chk({15'h0000, o_active_halt}, 16'h0000);
		fire(WDG_PRESCALE_DIV + 20, WDG_RST_PULSE_CYC);
		i_rtc_interrupt_enable <= 1'b0;
		do_reset();
	endtask : t_active

	task automatic t_halt();
		wr(WDG_CTRL_ADDR, 8'hC1);
		ev(3'h4);
		chk({15'h0000, o_halted}, 16'h0001);
		quiet(2 * WDG_PRESCALE_DIV + 100);
		rd_chk(WDG_CTRL_ADDR, 8'hC0);
		ev(3'h2);
		chk({15'h0000, o_halted}, 16'h0000);
		fire(WDG_PRESCALE_DIV + WDG_DELAY_SHORT + 20,
			WDG_RST_PULSE_CYC);
	endtask : t_halt

	// =====================================================
	// main sequence: power-on clear with reset, then scenarios
	initial begin
		i_bus = '{addr: 16'h0000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
		{i_halt_exec, i_ext_irq, i_osc_irq} = 3'h0;
		i_rtc_interrupt_enable = 1'b0;
		i_hw_wdg_opt = 1'b0;
		i_halt_reset_option = 1'b0;
		i_long_delay_sel = 1'b0;
		i_srst = 1'b1;
		i_por = 1'b1;
		repeat (8) @(posedge i_mclk);
		i_srst <= 1'b0;
		i_por <= 1'b0;
		@(posedge i_mclk);
		t_regs();
		t_opts();
		t_restart();
		t_count();
		t_active();
		t_halt();
		end_sim();
	end

endmodule : test_wdg_core

`default_nettype wire
